// ---- scc_regs.vh ----
// register offsets, field positions and reset values of the sysref clock control bank
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
// register indices (byte address is four times the index)
`define SCC_IDX_CTRL0 10'h030
`define SCC_IDX_STATUS 10'h031
`define SCC_IDX_DELAY 10'h032
`define SCC_IDX_MISC 10'h033
`define SCC_IDX_CLAMP 10'h034
`define SCC_IDX_SER 10'h040
`define SCC_IDX_IRQSTAT 10'h050
`define SCC_IDX_IRQMASK 10'h051
// reset values
`define SCC_RST_CTRL0 8'hc0
`define SCC_RST_STATUS_LOW 6'h07
`define SCC_RST_DELAY 8'h80
`define SCC_RST_MISC 8'hc3
`define SCC_RST_CLAMP 8'h2f
`define SCC_RST_SER 8'h04
// control register zero fields
`define SCC_BIT_RCVR_EN 7
`define SCC_BIT_PROC_EN 6
`define SCC_BIT_EDGE_CLR 5
`define SCC_BIT_MARG_CLR 4
`define SCC_BIT_CLK_DC 2
`define SCC_BIT_SYSREF_DC 1
`define SCC_BIT_SYNC_DC 0
// status fields
`define SCC_BIT_EDGE_SEEN 7
`define SCC_BIT_MARGINAL 6
// other fields
`define SCC_BIT_SYNC_PD 2
`define SCC_BIT_CLAMP_EN 5
`define SCC_DELAY_STEP_PS 20
// interrupt bits: 0 edge seen, 1 marginal capture
`define SCC_IRQ_EDGE 0
`define SCC_IRQ_MARG 1
`endif

// ---- scc_src.sv ----
// clock source model giving sysref pulses and a marginal capture level
`timescale 1ns/100ps
module scc_src (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic marg,
  output logic sysrefIn,
  output logic marginalIn
);
  logic [2:0] cnt = 3'h0;
  // a fire request launches a four-cycle pulse, long enough for the two-flop sync
  always @(posedge sys_clk) begin
    if (fire) cnt <= 3'h4;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
  assign sysrefIn = (cnt != 3'h0);
  assign marginalIn = marg && (cnt != 3'h0);
endmodule // scc_src

// ---- scc_sva.sv ----
// assertion checker for the sysref clock control register bank
`timescale 1ns/100ps
module scc_sva #(parameter DELAY_W = 4) (
  input wire logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest,
  input wire logic [11:0] avs_address,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [3:0] avs_byteenable, serializerPreEmphasis,
  input wire logic [DELAY_W-1:0] sysrefDelaySteps,
  input wire logic sysrefReceiverEnable, sysrefProcessorEnable, clockInputDcCoupled,
  input wire logic sysrefInputDcCoupled, syncInputDcCoupled, syncDifferentialPowerdown,
  input wire logic inputClampEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // a write counts only at the edge where waitrequest is low, low byte lane on
  wire logic [9:0] ix = avs_address[11:2];
  wire logic wt = avs_write && !avs_waitrequest && avs_byteenable[0];
  property p_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_first: assert property (p_first) else $error("request answered with no wait state");
  property p_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait state longer than one cycle");
  property p_stat; avs_read && !avs_waitrequest && ix == 10'h031 |-> avs_readdata[5:0] == 6'h07;
  endproperty
  a_stat: assert property (p_stat) else $error("status low bits wrong");
  property p_rst; $rose(rst_n) |-> sysrefReceiverEnable && sysrefProcessorEnable
    && inputClampEnable && serializerPreEmphasis == 4'h4; endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_ctrl; wt && ix == 10'h030 |=> {sysrefReceiverEnable, sysrefProcessorEnable,
    clockInputDcCoupled, sysrefInputDcCoupled, syncInputDcCoupled}
    == {$past(avs_writedata[7:6]), $past(avs_writedata[2:0])}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control outputs wrong");
  property p_dly; wt && ix == 10'h032 |=> sysrefDelaySteps == $past(avs_writedata[3:0]);
  endproperty
  a_dly: assert property (p_dly) else $error("delay steps wrong");
  property p_misc; wt && ix == 10'h033 |=> syncDifferentialPowerdown == $past(avs_writedata[2]);
  endproperty
  a_misc: assert property (p_misc) else $error("sync powerdown wrong");
  property p_ser; wt && ix == 10'h040 |=> serializerPreEmphasis == $past(avs_writedata[3:0]);
  endproperty
  a_ser: assert property (p_ser) else $error("pre-emphasis wrong");
endmodule // scc_sva

// ---- scc_sysref_clock_ctrl.v ----
// register bank and sysref capture logic of the clock generator area
//
// Summary of operation
// - receiver enable bit drives receiver, resets one
// - processor enable bit drives processor, resets one
// - sysref rising edge sets edge-seen status bit 7
// - write one then zero to bit5 clears edge-seen
// - edge near clock edge sets marginal bit 6
// - write one then zero to bit4 clears marginal
// - four-bit delay field steps sysref, resets zero
// - status low six bits always read 000111b
// - bits 2,1,0 select dc lvpecl clock/sysref/sync
// - misc bit 2 powers down differential sync receiver
// - clamp bit 5 enables input clamp, resets one
// - serializer pre-emphasis in bits 3..0, resets 4
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "scc_regs.vh"
module scc_sysref_clock_ctrl #(
  parameter DELAY_W = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg avs_response_err,
  input wire sysrefIn,
  input wire marginalIn,
  output wire sysrefReceiverEnable,
  output wire sysrefProcessorEnable,
  output wire [DELAY_W-1:0] sysrefDelaySteps,
  output reg sysrefDelayed,
  output wire clockInputDcCoupled,
  output wire sysrefInputDcCoupled,
  output wire syncInputDcCoupled,
  output wire syncDifferentialPowerdown,
  output wire inputClampEnable,
  output wire [3:0] serializerPreEmphasis,
  output wire irq
);
  localparam DLY_DEPTH = 1 << DELAY_W;

  reg [7:0] ctrlZero_reg;
  reg [7:0] delayCtrl_reg;
  reg [7:0] miscCtrl_reg;
  reg [7:0] clampCtrl_reg;
  reg [7:0] serCfg_reg;
  reg edgeSeen_reg;
  reg marginal_reg;
  reg [1:0] irqStat_reg;
  reg [1:0] irqMask_reg;
  reg ackPhase_reg;
  reg [1:0] sysrefSync_reg;
  reg [1:0] marginalSync_reg;
  reg sysrefPrev_reg;
  reg [DLY_DEPTH-1:0] delayLine_reg;
  wire [9:0] regIndex;
  wire wrSel;
  wire rdSel;
  wire edgeEvent;
  wire margEvent;
  wire edgeClrFall;
  wire margClrFall;
  wire wrCtrl0;
  reg [7:0] rdByte;
  reg hit;

  // one wait cycle per access: request taken on the edge where waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPhase_reg;
  assign regIndex = avs_address[11:2];
  assign wrSel = avs_write & ackPhase_reg & avs_byteenable[0];
  assign rdSel = avs_read & ~ackPhase_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackPhase_reg <= 1'b0;
    end else begin
      ackPhase_reg <= (avs_read | avs_write) & ~ackPhase_reg;
    end
  end

  // sysref and marginal indicator cross in through two flops each
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysrefSync_reg <= 2'h0;
      marginalSync_reg <= 2'h0;
      sysrefPrev_reg <= 1'b0;
    end else begin
      sysrefSync_reg <= {sysrefSync_reg[0], sysrefIn};
      marginalSync_reg <= {marginalSync_reg[0], marginalIn};
      sysrefPrev_reg <= sysrefSync_reg[1];
    end
  end

  // processing is gated by the processor enable; a disabled processor sees no edges
  // receiver gate sits after the synchroniser so only the second flop is read
  assign edgeEvent = sysrefReceiverEnable & sysrefProcessorEnable
    & sysrefSync_reg[1] & ~sysrefPrev_reg;
  assign margEvent = edgeEvent & marginalSync_reg[1];

  // delay line: one tap per nominal step, tap chosen by the delay field
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delayLine_reg <= {DLY_DEPTH{1'b0}};
      sysrefDelayed <= 1'b0;
    end else begin
      delayLine_reg <= {delayLine_reg[DLY_DEPTH-2:0],
        sysrefSync_reg[1] & sysrefReceiverEnable & sysrefProcessorEnable};
      sysrefDelayed <= delayLine_reg[sysrefDelaySteps];
    end
  end

  // clear acts on the written 1->0 transition of each clear bit
  assign wrCtrl0 = wrSel & (regIndex == `SCC_IDX_CTRL0);
  assign edgeClrFall = wrCtrl0 & ctrlZero_reg[`SCC_BIT_EDGE_CLR]
    & ~avs_writedata[`SCC_BIT_EDGE_CLR];
  assign margClrFall = wrCtrl0 & ctrlZero_reg[`SCC_BIT_MARG_CLR]
    & ~avs_writedata[`SCC_BIT_MARG_CLR];

  // sticky flags; a new event in the clearing cycle wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeSeen_reg <= 1'b0;
      marginal_reg <= 1'b0;
    end else begin
      if (edgeEvent) begin
        edgeSeen_reg <= 1'b1;
      end else if (edgeClrFall) begin
        edgeSeen_reg <= 1'b0;
      end
      if (margEvent) begin
        marginal_reg <= 1'b1;
      end else if (margClrFall) begin
        marginal_reg <= 1'b0;
      end
    end
  end

  // writable configuration registers, low byte lane only
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlZero_reg <= `SCC_RST_CTRL0;
      delayCtrl_reg <= `SCC_RST_DELAY;
      miscCtrl_reg <= `SCC_RST_MISC;
      clampCtrl_reg <= `SCC_RST_CLAMP;
      serCfg_reg <= `SCC_RST_SER;
      irqMask_reg <= 2'h0;
    end else if (wrSel) begin
      case (regIndex)
        `SCC_IDX_CTRL0: ctrlZero_reg <= avs_writedata[7:0];
        `SCC_IDX_DELAY: delayCtrl_reg <= avs_writedata[7:0];
        `SCC_IDX_MISC: miscCtrl_reg <= avs_writedata[7:0];
        `SCC_IDX_CLAMP: clampCtrl_reg <= avs_writedata[7:0];
        `SCC_IDX_SER: serCfg_reg <= avs_writedata[7:0];
        `SCC_IDX_IRQMASK: irqMask_reg <= avs_writedata[1:0];
        default: ctrlZero_reg <= ctrlZero_reg;
      endcase
    end
  end

  // interrupt status: events set, write one clears, set wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_reg <= 2'h0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~((wrSel && regIndex == `SCC_IDX_IRQSTAT) ?
        avs_writedata[1:0] : 2'h0)) | {margEvent, edgeEvent};
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // read mux
  always @* begin
    rdByte = 8'h00;
    hit = 1'b1;
    case (regIndex)
      `SCC_IDX_CTRL0: rdByte = ctrlZero_reg;
      `SCC_IDX_STATUS: rdByte = {edgeSeen_reg, marginal_reg, `SCC_RST_STATUS_LOW};
      `SCC_IDX_DELAY: rdByte = delayCtrl_reg;
      `SCC_IDX_MISC: rdByte = miscCtrl_reg;
      `SCC_IDX_CLAMP: rdByte = clampCtrl_reg;
      `SCC_IDX_SER: rdByte = serCfg_reg;
      `SCC_IDX_IRQSTAT: rdByte = {6'h00, irqStat_reg};
      `SCC_IDX_IRQMASK: rdByte = {6'h00, irqMask_reg};
      default: hit = 1'b0;
    endcase
  end

  // read data registered; unmapped reads return zero with error flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
      avs_response_err <= 1'b0;
    end else if (rdSel) begin
      avs_readdata <= {24'h000000, rdByte};
      avs_response_err <= ~hit;
    end else if (avs_write & ~ackPhase_reg) begin
      avs_response_err <= ~hit;
    end
  end

  // control outputs straight from register fields
  assign sysrefReceiverEnable = ctrlZero_reg[`SCC_BIT_RCVR_EN];
  assign sysrefProcessorEnable = ctrlZero_reg[`SCC_BIT_PROC_EN];
  assign clockInputDcCoupled = ctrlZero_reg[`SCC_BIT_CLK_DC];
  assign sysrefInputDcCoupled = ctrlZero_reg[`SCC_BIT_SYSREF_DC];
  assign syncInputDcCoupled = ctrlZero_reg[`SCC_BIT_SYNC_DC];
  assign sysrefDelaySteps = delayCtrl_reg[DELAY_W-1:0];
  assign syncDifferentialPowerdown = miscCtrl_reg[`SCC_BIT_SYNC_PD];
  assign inputClampEnable = clampCtrl_reg[`SCC_BIT_CLAMP_EN];
  assign serializerPreEmphasis = serCfg_reg[3:0];
endmodule // scc_sysref_clock_ctrl

// ---- testbench.sv ----
// self-checking bench for the sysref clock control register bank
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, fire = 1'b0;
  logic marg = 1'b0, er, avs_waitrequest, avs_response_err, sysrefIn, marginalIn, irq;
  logic [11:0] avs_address = 12'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'h0, serializerPreEmphasis, sysrefDelaySteps;
  logic sysrefReceiverEnable, sysrefProcessorEnable, clockInputDcCoupled, sysrefInputDcCoupled;
  logic syncInputDcCoupled, syncDifferentialPowerdown, inputClampEnable, sysrefDelayed;
  int bad_count = 0, check_count = 0;
  always #10 sys_clk = ~sys_clk;
  scc_sysref_clock_ctrl scc_sysref_clock_ctrl_i (.*);
  scc_src scc_src_i (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one access; request held until the rising edge where waitrequest is low
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    {avs_byteenable, avs_writedata} <= {4'h1, 24'h0, d};
    {avs_write, avs_read} <= {w, !w};
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        bad_count++;
        stop_test();
      end
    end while (avs_waitrequest !== 1'b0);
    {rd, er} = {avs_readdata, avs_response_err};
    {avs_write, avs_read} <= 2'b00;
    // let the register update settle before outputs are compared
    @(negedge sys_clk);
  endtask
  // sysref pulse measured through the delay line; expect 6 plus steps edges
  task automatic t_delay(input int s);
    int n;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    n = 1;
    while (sysrefDelayed !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, 6 + s);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [9:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  // one sysref pulse, then time for sync and edge detect
  task automatic pulse(input logic m);
    @(posedge sys_clk);
    {fire, marg} <= {1'b1, m};
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    logic [9:0] ix [6] = '{10'h030, 10'h031, 10'h032, 10'h033, 10'h034, 10'h040};
    logic [7:0] ex [6] = '{8'hc0, 8'h07, 8'h80, 8'hc3, 8'h2f, 8'h04};
    for (int k = 0; k < 6; k++) rchk(ix[k], ex[k]);
  endtask
  // power down processor first, then up receiver first
  task automatic t_power();
    bus(1'b1, 10'h030, 8'h80);
    chk({sysrefReceiverEnable, sysrefProcessorEnable}, 2'b10);
    bus(1'b1, 10'h030, 8'h00);
    chk({sysrefReceiverEnable, sysrefProcessorEnable}, 2'b00);
    bus(1'b1, 10'h030, 8'h80);
    bus(1'b1, 10'h030, 8'hc0);
    chk({sysrefReceiverEnable, sysrefProcessorEnable}, 2'b11);
  endtask
  // sticky flags, two-write clears, interrupt raise, mask and clear
  task automatic t_flags();
    bus(1'b1, 10'h051, 8'h01);
    pulse(1'b0);
    rchk(10'h031, 8'h87);
    chk(irq, 1'b1);
    bus(1'b1, 10'h030, 8'he0);
    rchk(10'h031, 8'h87);
    bus(1'b1, 10'h030, 8'hc0);
    rchk(10'h031, 8'h07);
    pulse(1'b1);
    rchk(10'h031, 8'hc7);
    bus(1'b1, 10'h050, 8'h01);
    chk(irq, 1'b0);
    bus(1'b1, 10'h030, 8'hd0);
    bus(1'b1, 10'h030, 8'hc0);
    rchk(10'h031, 8'h87);
  endtask
  task automatic t_fields();
    bus(1'b1, 10'h032, 8'h8f);
    chk(sysrefDelaySteps, 4'hf);
    t_delay(15);
    bus(1'b1, 10'h030, 8'hc7);
    chk({clockInputDcCoupled, sysrefInputDcCoupled, syncInputDcCoupled}, 3'h7);
    bus(1'b1, 10'h033, 8'hc7);
    chk(syncDifferentialPowerdown, 1'b1);
    bus(1'b1, 10'h034, 8'h0f);
    chk(inputClampEnable, 1'b0);
    bus(1'b1, 10'h040, 8'h09);
    chk(serializerPreEmphasis, 4'h9);
    rchk(10'h035, 8'h00);
    chk(er, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_power();
    t_flags();
    t_fields();
    stop_test();
  end
endmodule // testbench
bind scc_sysref_clock_ctrl scc_sva #(.DELAY_W(DELAY_W)) scc_sva_i (.*);
